// ---- sim/idc_host.sv ----
// host controller model driving the configuration register bank
`timescale 1ns/1ps

// ==========================================================
// host model
module idc_host (
  input  wire logic        CLK_I,
  output logic [3:0]       addr_o,
  output logic [15:0]      wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i
);
  initial begin
    addr_o = 4'h0;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge CLK_I);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge CLK_I);
    wr_o    <= 1'b0;
  endtask

  // answer is registered on the taking edge and read 1ns after it; absent answer reads as unknown
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge CLK_I);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge CLK_I);
    rd_o   <= 1'b0;
    #1;
    d = (rvalid_i === 1'b1) ? rdata_i : 16'hXXXX;
  endtask
endmodule

// ---- sim/testbench.sv ----
// self-checking bench of the configuration register bank
`timescale 1ns/1ps

module testbench;
  // ==========================================================
  // signals
  logic clk, rst_n, wdx, clr, ext;
  logic [3:0] a;
  logic [15:0] wd, rdv;
  logic wr, rd, rv, ph, su, tk, po, oen, lv;
  logic [12:0] flt;
  idc_pkg::idc_cfg_type cfg;
  wire pin = oen ? ext : po;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  idc_config_regs #(.WDT_CYC('{20, 40, 60, 80, 100, 120, 140, 160})) dut (
    .CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(a), .REG_WDATA_I(wd),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdv), .REG_RVALID_O(rv),
    .FAULTS_I(flt), .WDT_EXPIRED_I(wdx), .SEQ_CLEAR_I(clr), .PHASE_DIS_O(ph),
    .SUPPLY_DIS_O(su), .CFG_O(cfg), .OC_TIMER_TICK_O(tk), .FAULT_PIN_I(pin),
    .FAULT_PIN_O(po), .FAULT_PIN_OE_N_O(oen), .FAULT_PIN_LEVEL_O(lv));

  idc_host host (
    .CLK_I(clk), .addr_o(a), .wdata_o(wd), .wr_o(wr), .rd_o(rd),
    .rdata_i(rdv), .rvalid_i(rv));

  // ==========================================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // a hang ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================================
  // scenarios
  task automatic t_reset();
    logic [15:0] d;
    host.rd_reg(4'h4, d);
    chk("thresh", 16'h6311, d);
    host.rd_reg(4'h5, d);
    chk("clkwd", 16'hEF00, d);
    host.rd_reg(4'h6, d);
    chk("filt", 16'h1B24, d);
    host.rd_reg(4'h8, d);
    chk("mask", 16'h0000, d);
    host.rd_reg(4'hF, d);
    chk("unmapped", 16'h0000, d);
    chk("pos", 8'd100, cfg.pos_trip_mv);
    chk("neg", 8'd18, cfg.neg_trip_mv);
    chk("trim", 9'h1E5, {cfg.trim_qpct});
    chk("wdt", 160, cfg.wdt_cycles);
    chk("pdgl", 8'd20, cfg.pos_deglitch_cyc);
    chk("ndgl", 8'd20, cfg.neg_deglitch_cyc);
    chk("presc", 2'd0, cfg.prescale_sel);
    chk("bits", 3'b000, {cfg.bridge_48v, cfg.common_drain, cfg.rev_iso_en});
    $display("test reset done");
  endtask

  task automatic t_fields();
    logic [15:0] d;
    host.wr_reg(4'h4, 16'hFF80);
    host.rd_reg(4'h4, d);
    chk("thresh_rb", 16'h7F00, d);
    chk("pos_max", 8'd128, cfg.pos_trip_mv);
    chk("neg_min", 8'd1, cfg.neg_trip_mv);
    for (int i = 0; i < 8; i++) begin
      host.wr_reg(4'h5, 16'h101B | 16'(i << 8));
      host.rd_reg(4'h5, d);
      chk("clkwd_rb", 16'h101A | 16'(i << 8), d);
      chk("wdt_sel", 20 * (i + 1), cfg.wdt_cycles);
    end
    chk("trim_b1", 9'h012, cfg.trim_qpct);
    chk("bits", 3'b111, {cfg.bridge_48v, cfg.common_drain, cfg.rev_iso_en});
    $display("test fields done");
  endtask

  task automatic t_filt();
    logic [15:0] d;
    int n;
    for (int s = 0; s < 4; s++) begin
      host.wr_reg(4'h6, 16'(s << 6) | 16'hC03F);
      wt(10);
      n = 0;
      repeat (32) begin
        n += (tk === 1'b1);
        wt(1);
      end
      chk("ticks", 32 >> s, n);
    end
    chk("pdgl_max", 8'd35, cfg.pos_deglitch_cyc);
    chk("ndgl_max", 8'd35, cfg.neg_deglitch_cyc);
    host.wr_reg(4'h7, 16'hFFFF);
    host.rd_reg(4'h6, d);
    chk("filt_rb", 16'h00FF, d);
    $display("test filter done");
  endtask

  task automatic t_wdog();
    for (int o = 0; o < 2; o++) begin
      host.wr_reg(4'h5, 16'h0700 | 16'(o << 2));
      @(posedge clk);
      wdx <= 1'b1;
      @(posedge clk);
      wdx <= 1'b0;
      #1;
      chk("first", o ? 2'b01 : 2'b10, {ph, su});
      wt(1);
      chk("both", 2'b11, {ph, su});
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      wt(1);
      chk("cleared", 2'b00, {ph, su});
    end
    $display("test watchdog done");
  endtask

  task automatic t_pin();
    logic p;
    @(posedge clk);
    flt <= 13'h1000;
    wt(2);
    chk("fault_on", 2'b00, {po, oen});
    host.wr_reg(4'h8, 16'h1000);
    wt(2);
    chk("fault_masked", 2'b10, {po, oen});
    host.wr_reg(4'h8, 16'h2000);
    wt(2);
    p = po;
    wt(1);
    chk("clk_out", !p, po);
    host.wr_reg(4'h8, 16'h4000);
    wt(2);
    chk("tristate", 1'b1, oen);
    @(posedge clk);
    ext <= 1'b0;
    wt(8);
    chk("level_lo", 1'b0, lv);
    @(posedge clk);
    ext <= 1'b1;
    wt(8);
    chk("level_hi", 1'b1, lv);
    $display("test pin done");
  endtask

  // reset in mid-run must bring back the pin drive and the stored defaults
  task automatic t_rerun();
    logic [15:0] d;
    @(posedge clk);
    rst_n <= 1'b0;
    wt(2);
    chk("rst_pin", 2'b10, {po, oen});
    @(posedge clk);
    rst_n <= 1'b1;
    host.rd_reg(4'h8, d);
    chk("rst_mask", 16'h0000, d);
    host.rd_reg(4'h5, d);
    chk("rst_clkwd", 16'hEF00, d);
    $display("test rerun done");
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    wdx = 1'b0;
    clr = 1'b0;
    ext = 1'b1;
    flt = 13'h0000;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_filt();
    t_wdog();
    t_pin();
    t_rerun();
    wrap_up();
  end
endmodule

// ---- src/idc_cfg.svh ----
// constants of the isolator driver configuration register bank
`ifndef IDC_CFG_SVH
`define IDC_CFG_SVH

// ==========================================================
// register offsets and address width
`define IDC_ADDR_W        4
`define IDC_OFS_THRESH    4'h4
`define IDC_OFS_CLKWD     4'h5
`define IDC_OFS_FILT      4'h6
`define IDC_OFS_MASK      4'h8

// ==========================================================
// reset values and writable bits
`define IDC_RST_THRESH    16'h6311
`define IDC_RST_CLKWD     16'hEF00
`define IDC_RST_FILT      16'h1B24
`define IDC_RST_MASK      16'h0000
`define IDC_WMASK_THRESH  16'h7F7F
`define IDC_WMASK_CLKWD   16'hFF1E
`define IDC_WMASK_FILT    16'h3FFF
`define IDC_WMASK_MASK    16'h7FFF

// ==========================================================
// field positions (least significant bit)
`define IDC_POS_TRIP_LSB  8
`define IDC_NEG_TRIP_LSB  0
`define IDC_TRIM_LSB      11
`define IDC_WDT_LSB       8
`define IDC_BRIDGE_BIT    4
`define IDC_TOPO_BIT      3
`define IDC_ORDER_BIT     2
`define IDC_REVISO_BIT    1
`define IDC_PRESC_LSB     6
`define IDC_POSDGL_LSB    3
`define IDC_NEGDGL_LSB    0
`define IDC_PINFN_LSB     13
`define IDC_EXTMASK_BIT   12

// ==========================================================
// clock trim weights in quarter percent
`define IDC_TRIM_W0       9'h009
`define IDC_TRIM_W1       9'h012
`define IDC_TRIM_W2       9'h024
`define IDC_TRIM_W3       9'h048
`define IDC_TRIM_W4       9'h090

// ==========================================================
// timing
`define IDC_CLK_MHZ       20
`define IDC_DGL_STEP_NS   250
`define IDC_DGL_STEP_CYC  ((`IDC_DGL_STEP_NS * `IDC_CLK_MHZ + 999) / 1000)
`define IDC_WDT0_US       10200
`define IDC_WDT1_US       20500
`define IDC_WDT2_US       30800
`define IDC_WDT3_US       41000
`define IDC_WDT4_US       82000
`define IDC_WDT5_US       328000
`define IDC_WDT6_US       655000
`define IDC_WDT7_US       1310000

`endif

// ---- src/idc_config_regs.sv ----
// configuration register bank of the isolator gate-driver controller
`timescale 1ns/1ps
`include "idc_cfg.svh"

// Functional notes
// RULE1: positive trip level is code plus one mV
// RULE2: negative trip level is minus code plus one
// RULE3: clock trim bits add independent period weights
// RULE4: watchdog timeout chosen from eight values
// RULE5: order bit sets watchdog shutdown sequence
// RULE6: timer prescaler divides by 1, 2, 4, 8
// RULE7: positive deglitch time is code times 250ns
// RULE8: negative deglitch time is code times 250ns
// RULE9: fault pin: indicator, calibration clock, or input
// RULE10: mask bits keep faults off the pin
// RULE11: bridge voltage and topology select bits
// RULE12: reverse-supply current isolation enable bit
// RULE13: reads return last written values, no side effects; the code reads non-writable bits as zero
module idc_config_regs #(
  parameter int unsigned WDT_CYC [8] = '{
    `IDC_WDT0_US * `IDC_CLK_MHZ, `IDC_WDT1_US * `IDC_CLK_MHZ,
    `IDC_WDT2_US * `IDC_CLK_MHZ, `IDC_WDT3_US * `IDC_CLK_MHZ,
    `IDC_WDT4_US * `IDC_CLK_MHZ, `IDC_WDT5_US * `IDC_CLK_MHZ,
    `IDC_WDT6_US * `IDC_CLK_MHZ, `IDC_WDT7_US * `IDC_CLK_MHZ}
) (
  input  wire logic                   CLK_I,
  input  wire logic                   RST_N_I,
  input  wire logic [`IDC_ADDR_W-1:0] REG_ADDR_I,
  input  wire logic [15:0]            REG_WDATA_I,
  input  wire logic                   REG_WR_I,
  input  wire logic                   REG_RD_I,
  output logic [15:0]                 REG_RDATA_O,
  output logic                        REG_RVALID_O,
  input  wire logic [12:0]            FAULTS_I,
  input  wire logic                   WDT_EXPIRED_I,
  input  wire logic                   SEQ_CLEAR_I,
  output logic                        PHASE_DIS_O,
  output logic                        SUPPLY_DIS_O,
  output idc_pkg::idc_cfg_type        CFG_O,
  output logic                        OC_TIMER_TICK_O,
  input  wire logic                   FAULT_PIN_I,
  output logic                        FAULT_PIN_O,
  output logic                        FAULT_PIN_OE_N_O,
  output logic                        FAULT_PIN_LEVEL_O
);

  idc_pkg::idc_state_type s_r;
  idc_pkg::idc_state_type s_nxt;
  idc_pkg::idc_pin_type   pin_fn;
  logic                   presc_tick;
  logic                   fault_any;

  // ==========================================================
  // field decode, shared by reset and run time
  function automatic idc_pkg::idc_cfg_type decode(input logic [15:0] th,
                                                  input logic [15:0] cw,
                                                  input logic [15:0] fl);
    idc_pkg::idc_cfg_type c;
    logic signed [8:0]    t;
    logic [4:0]           tb;
    c = '0;
    tb = cw[`IDC_TRIM_LSB +: 5];
    c.pos_trip_mv = {1'b0, th[`IDC_POS_TRIP_LSB +: 7]} + 8'h01; // RULE1
    c.neg_trip_mv = {1'b0, th[`IDC_NEG_TRIP_LSB +: 7]} + 8'h01; // RULE2
    t = 9'sh000;
    // weights add independently; bit 4 shortens the period
    if (tb[0]) t = t + `IDC_TRIM_W0; // RULE3
    if (tb[1]) t = t + `IDC_TRIM_W1; // RULE3
    if (tb[2]) t = t + `IDC_TRIM_W2; // RULE3
    if (tb[3]) t = t + `IDC_TRIM_W3; // RULE3
    if (tb[4]) t = t - `IDC_TRIM_W4; // RULE3
    c.trim_qpct = t;
    c.wdt_cycles = WDT_CYC[cw[`IDC_WDT_LSB +: 3]]; // RULE4
    c.bridge_48v = cw[`IDC_BRIDGE_BIT]; // RULE11
    c.common_drain = cw[`IDC_TOPO_BIT]; // RULE11
    c.rev_iso_en = cw[`IDC_REVISO_BIT]; // RULE12
    c.prescale_sel = fl[`IDC_PRESC_LSB +: 2]; // RULE6
    c.pos_deglitch_cyc = 8'(fl[`IDC_POSDGL_LSB +: 3] * `IDC_DGL_STEP_CYC); // RULE7
    c.neg_deglitch_cyc = 8'(fl[`IDC_NEGDGL_LSB +: 3] * `IDC_DGL_STEP_CYC); // RULE8
    return c;
  endfunction

  idc_prescaler u_presc (
    .CLK_I   (CLK_I),
    .RST_N_I (RST_N_I),
    .sel_i   (s_r.cfg.prescale_sel),
    .tick_o  (presc_tick)
  );

  assign pin_fn = idc_pkg::idc_pin_type'(s_r.mask[`IDC_PINFN_LSB +: 2]);
  assign fault_any = |(FAULTS_I & ~s_r.mask[12:0]); // RULE10

  // ==========================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    // register access; a write only touches its own register
    if (REG_WR_I) begin
      case (REG_ADDR_I)
        `IDC_OFS_THRESH: s_nxt.thresh = REG_WDATA_I & `IDC_WMASK_THRESH; // RULE13
        `IDC_OFS_CLKWD:  s_nxt.clkwd = REG_WDATA_I & `IDC_WMASK_CLKWD; // RULE13
        `IDC_OFS_FILT:   s_nxt.filt = REG_WDATA_I & `IDC_WMASK_FILT; // RULE13
        `IDC_OFS_MASK:   s_nxt.mask = REG_WDATA_I & `IDC_WMASK_MASK; // RULE13
        default: ;
      endcase
    end
    if (REG_RD_I) begin
      s_nxt.rvalid = 1'b1;
      case (REG_ADDR_I)
        `IDC_OFS_THRESH: s_nxt.rdata = s_r.thresh; // RULE13
        `IDC_OFS_CLKWD:  s_nxt.rdata = s_r.clkwd; // RULE13
        `IDC_OFS_FILT:   s_nxt.rdata = s_r.filt; // RULE13
        `IDC_OFS_MASK:   s_nxt.rdata = s_r.mask; // RULE13
        default:         s_nxt.rdata = 16'h0000;
      endcase
    end
    s_nxt.cfg = decode(s_nxt.thresh, s_nxt.clkwd, s_nxt.filt);
    s_nxt.tick = presc_tick;

    // watchdog shutdown sequencer; a new expiry beats a clear
    case (s_r.seq)
      idc_pkg::IDC_SEQ_IDLE: begin
        if (WDT_EXPIRED_I) begin
          s_nxt.seq = idc_pkg::IDC_SEQ_FIRST;
          if (s_r.clkwd[`IDC_ORDER_BIT]) begin
            s_nxt.supply_dis = 1'b1; // RULE5
          end else begin
            s_nxt.phase_dis = 1'b1; // RULE5
          end
        end
      end
      idc_pkg::IDC_SEQ_FIRST: begin
        s_nxt.seq = idc_pkg::IDC_SEQ_DONE;
        s_nxt.phase_dis = 1'b1; // RULE5
        s_nxt.supply_dis = 1'b1; // RULE5
      end
      idc_pkg::IDC_SEQ_DONE: begin
        if (SEQ_CLEAR_I && !WDT_EXPIRED_I) begin
          s_nxt.seq = idc_pkg::IDC_SEQ_IDLE;
          s_nxt.phase_dis = 1'b0;
          s_nxt.supply_dis = 1'b0;
        end
      end
      default: begin
        s_nxt.seq = idc_pkg::IDC_SEQ_IDLE;
      end
    endcase

    // pin input: three flops, a change counts once the last two agree
    s_nxt.sync = {s_r.sync[1:0], FAULT_PIN_I};
    if (s_r.sync[2] == s_r.sync[1]) begin
      s_nxt.pin_level = s_r.sync[2];
    end

    // pin drive; fault indication is active low
    s_nxt.calib_clk = ~s_r.calib_clk;
    case (pin_fn)
      idc_pkg::IDC_PIN_FAULT: begin
        s_nxt.pin_oe_n = 1'b0; // RULE9
        s_nxt.pin_out = ~fault_any; // RULE10
      end
      idc_pkg::IDC_PIN_CLOCK: begin
        s_nxt.pin_oe_n = 1'b0; // RULE9
        s_nxt.pin_out = s_r.calib_clk; // RULE9
      end
      default: begin
        s_nxt.pin_oe_n = 1'b1; // RULE9
        s_nxt.pin_out = 1'b1;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_r <= '0;
      s_r.thresh <= `IDC_RST_THRESH;
      s_r.clkwd <= `IDC_RST_CLKWD;
      s_r.filt <= `IDC_RST_FILT;
      s_r.mask <= `IDC_RST_MASK; // RULE10
      s_r.cfg <= decode(`IDC_RST_THRESH, `IDC_RST_CLKWD, `IDC_RST_FILT);
      s_r.seq <= idc_pkg::IDC_SEQ_IDLE;
      s_r.pin_out <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign REG_RDATA_O = s_r.rdata;
  assign REG_RVALID_O = s_r.rvalid;
  assign PHASE_DIS_O = s_r.phase_dis;
  assign SUPPLY_DIS_O = s_r.supply_dis;
  assign CFG_O = s_r.cfg;
  assign OC_TIMER_TICK_O = s_r.tick;
  assign FAULT_PIN_O = s_r.pin_out;
  assign FAULT_PIN_OE_N_O = s_r.pin_oe_n;
  assign FAULT_PIN_LEVEL_O = s_r.pin_level;

  // ==========================================================
  // checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  AST_POS_TRIP: assert property ( // RULE1
    REG_WR_I && REG_ADDR_I == `IDC_OFS_THRESH
    |=> CFG_O.pos_trip_mv == {1'b0, $past(REG_WDATA_I[14:8])} + 8'h01)
    else $error("positive trip level wrong after write");

  AST_NEG_TRIP: assert property ( // RULE2
    REG_WR_I && REG_ADDR_I == `IDC_OFS_THRESH
    |=> CFG_O.neg_trip_mv == {1'b0, $past(REG_WDATA_I[6:0])} + 8'h01)
    else $error("negative trip level wrong after write");

  AST_TRIM: assert property ( // RULE3
    s_r.clkwd[15:11] == 5'h1D |-> CFG_O.trim_qpct == -9'sd27)
    else $error("clock trim sum wrong");

  AST_WDT: assert property ( // RULE4
    s_r.clkwd[10:8] == 3'h0 |-> CFG_O.wdt_cycles == WDT_CYC[0])
    else $error("watchdog timeout count wrong");

  AST_ORDER: assert property ( // RULE5
    s_r.seq == idc_pkg::IDC_SEQ_IDLE && WDT_EXPIRED_I && !s_r.clkwd[2]
    |=> PHASE_DIS_O && !SUPPLY_DIS_O ##1 PHASE_DIS_O && SUPPLY_DIS_O)
    else $error("watchdog shutdown order wrong");

  AST_ORDER_REV: assert property ( // RULE5
    s_r.seq == idc_pkg::IDC_SEQ_IDLE && WDT_EXPIRED_I && s_r.clkwd[`IDC_ORDER_BIT]
    |=> SUPPLY_DIS_O && !PHASE_DIS_O ##1 PHASE_DIS_O && SUPPLY_DIS_O)
    else $error("reversed watchdog shutdown order wrong");

  AST_PRESCALE: assert property ( // RULE6
    s_r.cfg.prescale_sel == 2'h0 [*4] |-> OC_TIMER_TICK_O)
    else $error("undivided prescaler missed a tick");

  AST_POS_DGL: assert property ( // RULE7
    s_r.filt[5:3] == 3'h7 |-> CFG_O.pos_deglitch_cyc == 8'd35)
    else $error("positive deglitch length wrong");

  AST_NEG_DGL: assert property ( // RULE8
    s_r.filt[2:0] == 3'h4 |-> CFG_O.neg_deglitch_cyc == 8'd20)
    else $error("negative deglitch length wrong");

  AST_PIN_TRI: assert property ( // RULE9
    s_r.mask[14] |=> FAULT_PIN_OE_N_O)
    else $error("fault pin driven in input mode");

  AST_MASK: assert property ( // RULE10
    pin_fn == idc_pkg::IDC_PIN_FAULT && s_r.mask[12] && FAULTS_I == 13'h1000
    |=> FAULT_PIN_O)
    else $error("masked external fault reached the pin");

  AST_READBACK: assert property ( // RULE13
    REG_RD_I && REG_ADDR_I == `IDC_OFS_MASK
    |=> REG_RVALID_O && REG_RDATA_O == $past(s_r.mask))
    else $error("readback differs from stored value");

endmodule

// ---- src/idc_pkg.sv ----
// types of the isolator driver configuration register bank
package idc_pkg;

  // ==========================================================
  // modes and states
  typedef enum logic [1:0] {
    IDC_PIN_FAULT,
    IDC_PIN_CLOCK,
    IDC_PIN_IN_A,
    IDC_PIN_IN_B
  } idc_pin_type;

  typedef enum logic [1:0] {
    IDC_SEQ_IDLE,
    IDC_SEQ_FIRST,
    IDC_SEQ_DONE
  } idc_seq_type;

  // ==========================================================
  // decoded configuration
  typedef struct packed {
    logic [7:0]        pos_trip_mv;
    logic [7:0]        neg_trip_mv;
    logic signed [8:0] trim_qpct;
    logic [31:0]       wdt_cycles;
    logic              bridge_48v;
    logic              common_drain;
    logic              rev_iso_en;
    logic [1:0]        prescale_sel;
    logic [7:0]        pos_deglitch_cyc;
    logic [7:0]        neg_deglitch_cyc;
  } idc_cfg_type;

  typedef struct packed {
    logic [15:0] thresh;
    logic [15:0] clkwd;
    logic [15:0] filt;
    logic [15:0] mask;
    idc_cfg_type cfg;
    logic [15:0] rdata;
    logic        rvalid;
    idc_seq_type seq;
    logic        phase_dis;
    logic        supply_dis;
    logic [2:0]  sync;
    logic        pin_level;
    logic        pin_out;
    logic        pin_oe_n;
    logic        calib_clk;
    logic        tick;
  } idc_state_type;

  typedef struct packed {
    logic [2:0] cnt;
    logic       tick;
  } idc_presc_type;

endpackage

// ---- src/idc_prescaler.sv ----
// overcurrent timer clock prescaler: one tick every 1, 2, 4 or 8 cycles
`timescale 1ns/1ps

module idc_prescaler (
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);

  idc_pkg::idc_presc_type s_r;
  idc_pkg::idc_presc_type s_nxt;
  logic [2:0]             mask;

  // ==========================================================
  // divider
  always_comb begin
    mask = 3'h0;
    case (sel_i)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
      default: mask = 3'h0;
    endcase
    s_nxt = s_r;
    s_nxt.cnt = s_r.cnt + 3'h1;
    s_nxt.tick = (s_r.cnt & mask) == mask; // RULE6
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_o = s_r.tick;

endmodule
